// ---- rtl/modbus_defines.svh ----
// constants of the serial slave: timing, codes, register map
`ifndef MODBUS_DEFINES_SVH
`define MODBUS_DEFINES_SVH

// timing in own units
`define CLOCK_HZ        125000000
`define BAUD_BPS        2400
`define CHAR_BITS       11
`define GAP_TENTHS      15

// frame layout
`define POS_ADDR        8'h00
`define POS_FUNC        8'h01
`define POS_REG_HI      8'h02
`define POS_REG_LO      8'h03
`define POS_QTY_HI      8'h04
`define POS_QTY_LO      8'h05
`define POS_BCNT        8'h06
`define POS_DATA_HI     8'h07
`define POS_DATA_LO     8'h08
`define FRAME_MAX       8'hff
`define FRAME_MIN       8'h04
`define LEN_FIXED       8'h08
`define LEN_MULTI_HDR   9'h009

// function and exception codes
`define FN_READ         8'h03
`define FN_WRITE_ONE    8'h06
`define FN_WRITE_MULTI  8'h10
`define EXC_FLAG        8'h80
`define EXC_NONE        8'h00
`define EXC_FUNC        8'h01
`define EXC_ADDR        8'h02
`define EXC_VALUE       8'h03
`define BCAST_ADDR      8'h00

// register map
`define REG_VERSION     16'h0100
`define REG_RESET       16'h0101
`define REG_ADDRESS     16'h0120
`define ADDR_DEFAULT    8'h01
`define ADDR_MIN        16'h0001
`define ADDR_MAX        16'h00f7
`define RESET_MAX       16'h0001
`define MAX_READ        16'h007d
`define MAX_WRITE       16'h007b

// checksum
`define CRC_POLY        16'ha001
`define CRC_INIT        16'hffff
`define CRC_RESIDUE     16'h0000

`endif

// ---- rtl/modbus_pkg.sv ----
// state types of the serial slave
package modbus_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    S_RECV   = 2'b00,
    S_DECIDE = 2'b01,
    S_SEND   = 2'b10,
    S_FINISH = 2'b11
  } slave_state_t;
endpackage

// ---- rtl/uart_byte_rx.sv ----
// serial character receiver, samples at bit centres
`timescale 1ns/10ps
`default_nettype none
module uart_byte_rx #(
  parameter int unsigned BIT_CYCLES = 52083,
  parameter int unsigned CW         = 20
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // line
  input  wire logic       rxd,
  // received character
  output logic [7:0]      byte_data,
  output logic            byte_valid,
  output logic            byte_bad
);
  logic                   rx_meta;
  logic                   rx_s;
  modbus_pkg::rx_state_t  state;
  logic [CW-1:0]          cnt;
  logic [2:0]             bits;
  logic [7:0]             shift;

  always_ff @(posedge clock) begin
    rx_meta <= rxd;
    rx_s    <= rx_meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= modbus_pkg::RX_IDLE;
      cnt        <= '0;
      bits       <= 3'h0;
      shift      <= 8'h00;
      byte_data  <= 8'h00;
      byte_valid <= 1'b0;
      byte_bad   <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      unique case (state)
        modbus_pkg::RX_IDLE: begin
          if (!rx_s) begin
            cnt   <= CW'(BIT_CYCLES / 2);
            state <= modbus_pkg::RX_START;
          end
        end
        modbus_pkg::RX_START: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (!rx_s) begin
            cnt   <= CW'(BIT_CYCLES - 1);
            bits  <= 3'h0;
            state <= modbus_pkg::RX_DATA;
          end else begin
            state <= modbus_pkg::RX_IDLE;
          end
        end
        modbus_pkg::RX_DATA: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            // lsb first
            shift <= {rx_s, shift[7:1]};
            cnt   <= CW'(BIT_CYCLES - 1);
            bits  <= bits + 1'b1;
            if (bits == 3'h7) begin
              state <= modbus_pkg::RX_STOP;
            end
          end
        end
        modbus_pkg::RX_STOP: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            byte_data  <= shift;
            byte_valid <= 1'b1;
            byte_bad   <= !rx_s;
            state      <= modbus_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule // uart_byte_rx
`default_nettype wire

// ---- rtl/modbus_rtu_sensor_slave.sv ----
// serial slave protocol engine: frame receive, decode, reply
//
// How it works
// [R01] Line runs at 2400 bits per second from start-up.
// [R02] Character is start bit, eight data bits, no parity, two stop bits.
// [R03] Half duplex; device transmits only to answer a request, never concurrently.
// [R04] Idle longer than one and a half characters ends a frame.
// [R05] Frame is address, function, 0 to 251 payload bytes, checksum.
// [R06] Address zero executes as broadcast with no reply.
// [R07] Other addresses act only when equal to own address.
// [R08] Every reply starts with own slave address.
// [R09] Read request: function 0x03, start register, count, high byte first.
// [R10] Read reply: 0x03, byte count, register values high byte first.
// [R11] Single write request: 0x06, register, value, high byte first.
// [R12] Single write reply echoes register and value with fresh checksum.
// [R13] Multi write request: 0x10, start, count, byte count, data words.
// [R14] Multi write reply: 0x10, start register, count, checksum, no data.
// [R15] Failed request answered with function plus 0x80 and exception code.
// [R16] Byte count is content length in bytes; zero means none.
// [R17] Checksum: CRC-16, reflected poly 0xA001, preset 0xFFFF, lsb first.
// [R18] Checksum covers address through last payload byte, data bits only.
// [R19] Received checksum is recomputed; a mismatch invalidates the frame.
// [R20] Checksum sent low byte first, then high byte.
// [R21] Version register returns major high byte, minor low byte.
// [R22] Writing one to reset register resets device; only 0 and 1 accepted.
// [R23] Own address from settings register 1..247, default 1, applied at reset.
// [R24] Frames with bad checksum are dropped silently without any reply.
// [R25] Bad function, register or value answered with codes 01, 02, 03.
`include "modbus_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module modbus_rtu_sensor_slave #(
  // [R01] bit time from clock rate
  parameter int unsigned BIT_CYCLES    = `CLOCK_HZ / `BAUD_BPS,
  // [R04] least gap, rounded up
  parameter int unsigned GAP_CYCLES    =
    (BIT_CYCLES * `CHAR_BITS * `GAP_TENTHS + 9) / 10,
  parameter int unsigned CW            = 20,
  parameter logic [7:0]  VERSION_MAJOR = 8'h01,
  parameter logic [7:0]  VERSION_MINOR = 8'h00
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // transceiver
  input  wire logic       rxd,
  output logic            txd,
  output logic            tx_oe_n,
  // device control
  output logic            soft_reset_pulse,
  output logic [7:0]      slave_address
);
  // [R17] one byte through the reflected crc
  function automatic logic [15:0] crc_byte(input logic [15:0] crc_in, input logic [7:0] d);
    logic [15:0] c;
    c = crc_in ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic readable(input logic [15:0] a);
    return (a == `REG_VERSION) || (a == `REG_ADDRESS);
  endfunction

  function automatic logic writable(input logic [15:0] a);
    return (a == `REG_RESET) || (a == `REG_ADDRESS);
  endfunction

  // [R22] [R23] accepted value ranges
  function automatic logic value_ok(input logic [15:0] a, input logic [15:0] v);
    if (a == `REG_ADDRESS) begin
      return (v >= `ADDR_MIN) && (v <= `ADDR_MAX);
    end
    return v <= `RESET_MAX;
  endfunction

  logic [7:0]                rx_byte;
  logic                      rx_valid;
  logic                      rx_bad;
  modbus_pkg::slave_state_t  state;
  logic [7:0]                rx_count;
  logic [15:0]               rx_crc;
  logic                      frame_bad;
  logic                      frame_done;
  logic [CW-1:0]             gap_cnt;
  logic [7:0]                f_addr;
  logic [7:0]                f_func;
  logic [15:0]               f_reg;
  logic [15:0]               f_qty;
  logic [7:0]                f_bcnt;
  logic [15:0]               f_data;
  logic [7:0]                addr_setting;
  logic                      reset_pending;
  logic                      frame_ok;
  logic [7:0]                next_exc;
  logic [15:0]               wdata;
  logic [7:0]                tx_buf [0:5];
  logic [2:0]                tx_len;
  logic [3:0]                tx_idx;
  logic [15:0]               tx_crc;
  logic [9:0]                tx_shift;
  logic [3:0]                tx_bits;
  logic [CW-1:0]             tx_cnt;
  logic                      send_done;

  uart_byte_rx #(
    .BIT_CYCLES (BIT_CYCLES),
    .CW         (CW)
  ) u_rx (
    .clock      (clock),
    .rst        (rst),
    .rxd        (rxd),
    .byte_data  (rx_byte),
    .byte_valid (rx_valid),
    .byte_bad   (rx_bad)
  );

  // frame acceptance
  always_comb begin
    frame_ok = !frame_bad && (rx_count >= `FRAME_MIN)
      // [R19] residue zero when checksum matches
      && (rx_crc == `CRC_RESIDUE)
      // [R06] [R07] own or broadcast
      && ((f_addr == slave_address) || (f_addr == `BCAST_ADDR));
  end

  // frame assembly and gap detection
  always_ff @(posedge clock) begin
    if (rst || state != modbus_pkg::S_RECV || (frame_done && !frame_ok)) begin
      rx_count   <= 8'h00;
      rx_crc     <= `CRC_INIT;
      frame_bad  <= 1'b0;
      frame_done <= 1'b0;
      gap_cnt    <= '0;
    end else begin
      frame_done <= 1'b0;
      if (rx_valid) begin
        gap_cnt <= '0;
        // [R05] longest frame, extra bytes spoil it
        if (rx_count == `FRAME_MAX || rx_bad) begin
          frame_bad <= 1'b1;
        end
        if (rx_count != `FRAME_MAX) begin
          rx_count <= rx_count + 1'b1;
        end
        // [R18] data bits only, every byte
        rx_crc <= crc_byte(rx_crc, rx_byte);
      end else if (rx_count != 8'h00) begin
        // [R04] end of frame on long idle
        if (gap_cnt == CW'(GAP_CYCLES - 1)) begin
          frame_done <= 1'b1;
          gap_cnt    <= '0;
        end else if (!frame_done) begin
          gap_cnt <= gap_cnt + 1'b1;
        end
      end
    end
  end

  // [R09] [R11] [R13] field capture, high byte first
  always_ff @(posedge clock) begin
    if (rst) begin
      f_addr <= 8'h00;
      f_func <= 8'h00;
      f_reg  <= 16'h0000;
      f_qty  <= 16'h0000;
      f_bcnt <= 8'h00;
      f_data <= 16'h0000;
    end else if (rx_valid && state == modbus_pkg::S_RECV) begin
      case (rx_count)
        `POS_ADDR:    f_addr        <= rx_byte;
        `POS_FUNC:    f_func        <= rx_byte;
        `POS_REG_HI:  f_reg[15:8]   <= rx_byte;
        `POS_REG_LO:  f_reg[7:0]    <= rx_byte;
        `POS_QTY_HI:  f_qty[15:8]   <= rx_byte;
        `POS_QTY_LO:  f_qty[7:0]    <= rx_byte;
        `POS_BCNT:    f_bcnt        <= rx_byte;
        `POS_DATA_HI: f_data[15:8]  <= rx_byte;
        `POS_DATA_LO: f_data[7:0]   <= rx_byte;
        default: ;
      endcase
    end
  end

  // request decode
  always_comb begin
    next_exc = `EXC_NONE;
    wdata    = (f_func == `FN_WRITE_ONE) ? f_qty : f_data;
    unique case (f_func)
      `FN_READ: begin
        if (rx_count != `LEN_FIXED || f_qty == 16'h0000 || f_qty > `MAX_READ) begin
          next_exc = `EXC_VALUE;
        end else if (f_qty != 16'h0001 || !readable(f_reg)) begin
          // no two readable registers are adjacent
          next_exc = `EXC_ADDR;
        end
      end
      `FN_WRITE_ONE: begin
        if (rx_count != `LEN_FIXED) begin
          next_exc = `EXC_VALUE;
        end else if (!writable(f_reg)) begin
          next_exc = `EXC_ADDR;
        end else if (!value_ok(f_reg, wdata)) begin
          next_exc = `EXC_VALUE;
        end
      end
      `FN_WRITE_MULTI: begin
        // [R16] byte count must match the words
        if ({1'b0, rx_count} != `LEN_MULTI_HDR + {1'b0, f_bcnt}
            || f_qty == 16'h0000 || f_qty > `MAX_WRITE
            || {8'h00, f_bcnt} != {f_qty[14:0], 1'b0}) begin
          next_exc = `EXC_VALUE;
        end else if (f_qty != 16'h0001 || !writable(f_reg)) begin
          next_exc = `EXC_ADDR;
        end else if (!value_ok(f_reg, wdata)) begin
          next_exc = `EXC_VALUE;
        end
      end
      // [R25] unsupported function
      default: next_exc = `EXC_FUNC;
    endcase
  end

  // sequence control
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= modbus_pkg::S_RECV;
    end else begin
      unique case (state)
        modbus_pkg::S_RECV: begin
          // [R24] bad frames never leave receive
          if (frame_done && frame_ok) begin
            state <= modbus_pkg::S_DECIDE;
          end
        end
        modbus_pkg::S_DECIDE: begin
          // [R06] broadcast sends nothing
          state <= (f_addr == `BCAST_ADDR) ? modbus_pkg::S_FINISH : modbus_pkg::S_SEND;
        end
        modbus_pkg::S_SEND: begin
          if (send_done) begin
            state <= modbus_pkg::S_FINISH;
          end
        end
        modbus_pkg::S_FINISH: state <= modbus_pkg::S_RECV;
      endcase
    end
  end

  // register writes and soft reset
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_setting     <= `ADDR_DEFAULT;
      slave_address    <= `ADDR_DEFAULT;
      reset_pending    <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= 1'b0;
      if (state == modbus_pkg::S_DECIDE && next_exc == `EXC_NONE && f_func != `FN_READ) begin
        if (f_reg == `REG_ADDRESS) begin
          addr_setting <= wdata[7:0];
        end
        // [R22] one triggers, zero is accepted and ignored
        if (f_reg == `REG_RESET && wdata[0]) begin
          reset_pending <= 1'b1;
        end
      end
      // [R22] [R23] reset after the reply, new address applies
      if (state == modbus_pkg::S_FINISH && reset_pending) begin
        reset_pending    <= 1'b0;
        soft_reset_pulse <= 1'b1;
        slave_address    <= addr_setting;
      end
    end
  end

  // reply assembly
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_len <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        tx_buf[i] <= 8'h00;
      end
    end else if (state == modbus_pkg::S_DECIDE) begin
      // [R08] own address first
      tx_buf[0] <= slave_address;
      if (next_exc != `EXC_NONE) begin
        // [R15] exception reply
        tx_buf[1] <= f_func | `EXC_FLAG;
        tx_buf[2] <= next_exc;
        tx_len    <= 3'h3;
      end else if (f_func == `FN_READ) begin
        // [R10] [R21] one register, two bytes
        tx_buf[1] <= f_func;
        tx_buf[2] <= 8'h02;
        tx_buf[3] <= (f_reg == `REG_VERSION) ? VERSION_MAJOR : 8'h00;
        tx_buf[4] <= (f_reg == `REG_VERSION) ? VERSION_MINOR : addr_setting;
        tx_len    <= 3'h5;
      end else begin
        // [R12] [R14] echo register and value or count
        tx_buf[1] <= f_func;
        tx_buf[2] <= f_reg[15:8];
        tx_buf[3] <= f_reg[7:0];
        tx_buf[4] <= f_qty[15:8];
        tx_buf[5] <= f_qty[7:0];
        tx_len    <= 3'h6;
      end
    end
  end

  // character transmitter
  always_ff @(posedge clock) begin
    if (rst || state != modbus_pkg::S_SEND) begin
      tx_idx    <= 4'h0;
      tx_crc    <= `CRC_INIT;
      tx_shift  <= 10'h3ff;
      tx_bits   <= 4'h0;
      tx_cnt    <= '0;
      txd       <= 1'b1;
      send_done <= 1'b0;
    end else if (tx_bits == 4'h0) begin
      if (tx_idx == {1'b0, tx_len} + 4'h2) begin
        send_done <= 1'b1;
      end else begin
        // [R02] start bit now, eight data then two stop
        txd     <= 1'b0;
        tx_bits <= 4'hb;
        tx_cnt  <= CW'(BIT_CYCLES - 1);
        tx_idx  <= tx_idx + 1'b1;
        if (tx_idx < {1'b0, tx_len}) begin
          tx_shift <= {2'b11, tx_buf[tx_idx[2:0]]};
          // [R18] crc over address through payload
          tx_crc   <= crc_byte(tx_crc, tx_buf[tx_idx[2:0]]);
        end else if (tx_idx == {1'b0, tx_len}) begin
          // [R20] low byte first
          tx_shift <= {2'b11, tx_crc[7:0]};
        end else begin
          tx_shift <= {2'b11, tx_crc[15:8]};
        end
      end
    end else if (tx_cnt != '0) begin
      tx_cnt <= tx_cnt - 1'b1;
    end else begin
      tx_cnt   <= CW'(BIT_CYCLES - 1);
      tx_bits  <= tx_bits - 1'b1;
      txd      <= (tx_bits == 4'h1) ? 1'b1 : tx_shift[0];
      tx_shift <= {1'b1, tx_shift[9:1]};
    end
  end

  // [R03] drive the line only while replying
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_oe_n <= 1'b1;
    end else begin
      tx_oe_n <= (state != modbus_pkg::S_SEND);
    end
  end
endmodule // modbus_rtu_sensor_slave
`default_nettype wire

// ---- verification/modbus_slave_checker_props.sv ----
// port assertions of the serial slave
`timescale 1ns/10ps
`default_nettype none
module modbus_slave_checker #(
  parameter int unsigned BIT_CYCLES = 16,
  parameter int unsigned GAP_CYCLES = 264
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // line
  input wire logic       rxd,
  input wire logic       txd,
  input wire logic       tx_oe_n,
  // control
  input wire logic       soft_reset_pulse,
  input wire logic [7:0] slave_address
);
  logic [31:0] idle_cnt;

  // clocks of idle receive line
  always_ff @(posedge clock) begin
    if (rst || !rxd) begin
      idle_cnt <= 32'h00000000;
    end else if (idle_cnt != 32'hffffffff) begin
      idle_cnt <= idle_cnt + 32'h00000001;
    end
  end

  AST_RESET_STATE:
    assert property (@(posedge clock) rst |=> tx_oe_n && txd && !soft_reset_pulse
      && slave_address == 8'h01) else $error("outputs not at reset values");
  AST_IDLE_HIGH:
    assert property (@(posedge clock) disable iff (rst) tx_oe_n |-> txd)
    else $error("txd low while driver off");
  AST_NO_OVERLAP:
    assert property (@(posedge clock) disable iff (rst) !rxd |-> tx_oe_n)
    else $error("driver on while master sends");
  AST_GAP_FIRST:
    assert property (@(posedge clock) disable iff (rst)
      $fell(tx_oe_n) |-> idle_cnt >= GAP_CYCLES) else $error("reply before frame gap");
  AST_START_BIT:
    assert property (@(posedge clock) disable iff (rst) $fell(tx_oe_n) |-> (!txd) [*8])
    else $error("reply does not open with start bit");
  AST_STOP_BITS:
    assert property (@(posedge clock) disable iff (rst)
      $rose(tx_oe_n) |-> $past(txd, 2) && $past(txd, 24)) else $error("stop bits not high");
  AST_PULSE_ONE:
    assert property (@(posedge clock) disable iff (rst)
      soft_reset_pulse |-> tx_oe_n ##1 !soft_reset_pulse) else $error("bad reset pulse");
  AST_ADDR_RANGE:
    assert property (@(posedge clock) disable iff (rst)
      slave_address >= 8'h01 && slave_address <= 8'hf7) else $error("address out of range");
  AST_ADDR_HOLD:
    assert property (@(posedge clock) disable iff (rst) !$stable(slave_address) |->
      soft_reset_pulse || $past(soft_reset_pulse) || $past(rst))
    else $error("address changed without reset");
endmodule // modbus_slave_checker

bind modbus_rtu_sensor_slave modbus_slave_checker #(
  .BIT_CYCLES(BIT_CYCLES),
  .GAP_CYCLES(GAP_CYCLES)
) u_chk (
  .clock(clock),
  .rst(rst),
  .rxd(rxd),
  .txd(txd),
  .tx_oe_n(tx_oe_n),
  .soft_reset_pulse(soft_reset_pulse),
  .slave_address(slave_address)
);
`default_nettype wire

// ---- verification/modbus_master_model.sv ----
// bus master model: sends requests, receives replies
`timescale 1ns/10ps
`default_nettype none
module modbus_master_model #(
  parameter int BIT_CYCLES = 16
) (
  // clock
  input wire logic  clock,
  // bus
  output var logic  rxd,
  input wire logic  txd,
  input wire logic  tx_oe_n
);
  // biased bus idles high
  initial rxd = 1'b1;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction

  // start, data lsb first, two stop, no gaps
  task automatic put_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clock);
      rxd = f[i];
      repeat (BIT_CYCLES - 1) @(negedge clock);
    end
  endtask

  // crc from address on, low byte first
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = crc_step(c, q[i]);
      put_byte(q[i]);
    end
    put_byte(c[7:0] ^ {7'h00, bad});
    put_byte(c[15:8]);
  endtask

  // one reply character sampled at bit centres
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while ((tx_oe_n !== 1'b0 || txd !== 1'b0) && n < 4000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 4000)
      return;
    repeat (BIT_CYCLES / 2) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(negedge clock);
      b[i] = txd;
    end
    repeat (BIT_CYCLES) @(negedge clock);
    ok = (txd === 1'b1) && (tx_oe_n === 1'b0);
  endtask
endmodule // modbus_master_model
`default_nettype wire

// ---- verification/modbus_rtu_sensor_slave_test.sv ----
// self-checking bench of the serial slave
`timescale 1ns/10ps
`default_nettype none
module modbus_rtu_sensor_slave_test;
  localparam int BIT = 16;
  localparam int GAP = 264;
  typedef logic [7:0] bytes_t[$];
  logic       clock;
  logic       rst;
  logic       rxd;
  logic       txd;
  logic       tx_oe_n;
  logic       soft_reset_pulse;
  logic [7:0] slave_address;
  int         err_total;
  int         n_tests;

  modbus_rtu_sensor_slave #(.BIT_CYCLES(BIT), .GAP_CYCLES(GAP)) dut (
    .clock(clock), .rst(rst), .rxd(rxd), .txd(txd), .tx_oe_n(tx_oe_n),
    .soft_reset_pulse(soft_reset_pulse), .slave_address(slave_address));
  modbus_master_model #(.BIT_CYCLES(BIT)) m (
    .clock(clock), .rxd(rxd), .txd(txd), .tx_oe_n(tx_oe_n));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // request, then expected reply bytes or silence
  task automatic xact(input int nq, input logic [71:0] q, input int nr, input logic [71:0] r,
                      input logic bad);
    bytes_t      req;
    bytes_t      rsp;
    logic [7:0]  b;
    logic        ok;
    logic [15:0] c;
    int          n;
    for (int i = nq - 1; i >= 0; i--)
      req.push_back(q[8 * i +: 8]);
    for (int i = nr - 1; i >= 0; i--)
      rsp.push_back(r[8 * i +: 8]);
    m.send(req, bad);
    n = 0;
    c = 16'hffff;
    foreach (rsp[i])
      c = m.crc_step(c, rsp[i]);
    if (nr == 0) begin
      repeat (GAP + 40 * BIT) begin
        @(negedge clock);
        n += int'(tx_oe_n !== 1'b1);
      end
      check(16'(n), 16'h0000);
      return;
    end
    rsp.push_back(c[7:0]);
    rsp.push_back(c[15:8]);
    foreach (rsp[i]) begin
      m.get_byte(b, ok);
      check({7'h00, ok, b}, {8'h01, rsp[i]});
      if (!ok)
        tally_and_finish();
    end
    while (tx_oe_n !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check({15'h0000, tx_oe_n}, 16'h0001);
  endtask

  // soft reset pulse, then new address in use
  task automatic wait_pulse(input logic [7:0] addr);
    int n;
    n = 0;
    while (soft_reset_pulse !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check({15'h0000, soft_reset_pulse}, 16'h0001);
    if (n >= 400)
      tally_and_finish();
    @(negedge clock);
    check({8'h00, slave_address}, {8'h00, addr});
  endtask

  initial begin
    rst = 1'b1;
    err_total = 0;
    n_tests = 0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    check({8'h00, slave_address}, 16'h0001);
    xact(6, 72'h010301000001, 5, 72'h0103020100, 1'b0);
    xact(6, 72'h010601200005, 6, 72'h010601200005, 1'b0);
    xact(6, 72'h010301200001, 5, 72'h0103020005, 1'b0);
    check({8'h00, slave_address}, 16'h0001);
    xact(6, 72'h010301000001, 0, 72'h0, 1'b1);
    xact(6, 72'h020301000001, 0, 72'h0, 1'b0);
    xact(6, 72'h010401000001, 3, 72'h018401, 1'b0);
    xact(6, 72'h010301010001, 3, 72'h018302, 1'b0);
    xact(6, 72'h010302000001, 3, 72'h018302, 1'b0);
    xact(6, 72'h010601200000, 3, 72'h018603, 1'b0);
    xact(6, 72'h010601010002, 3, 72'h018603, 1'b0);
    xact(7, 72'h01100101000000, 3, 72'h019003, 1'b0);
    xact(9, 72'h011001010001020001, 6, 72'h011001010001, 1'b0);
    wait_pulse(8'h05);
    xact(6, 72'h000601200007, 0, 72'h0, 1'b0);
    xact(6, 72'h050601010001, 6, 72'h050601010001, 1'b0);
    wait_pulse(8'h07);
    xact(6, 72'h070601010000, 6, 72'h070601010000, 1'b0);
    xact(6, 72'h070301000001, 5, 72'h0703020100, 1'b0);
    xact(6, 72'h010301000001, 0, 72'h0, 1'b0);
    tally_and_finish();
  end
endmodule // modbus_rtu_sensor_slave_test
`default_nettype wire
